/* design/dual_timer_pkg.sv */
// Constants shared by the dual 8-bit timer and its prescaler.
`default_nettype none
package dual_timer_pkg;
  localparam int ADDR_W  = 3;
  localparam int DATA_W  = 16;
  localparam int CH_N    = 2;
  localparam int DIV_N   = 6;
  localparam int PRESC_W = 13;

  // Register indices on the plain register port.
  localparam logic [2:0] IDX_COUNT  = 3'h0;
  localparam logic [2:0] IDX_CMPA   = 3'h1;
  localparam logic [2:0] IDX_CMPB   = 3'h2;
  localparam logic [2:0] IDX_CTRL0  = 3'h3;
  localparam logic [2:0] IDX_CTRL1  = 3'h4;
  localparam logic [2:0] IDX_FLAGS0 = 3'h5;
  localparam logic [2:0] IDX_FLAGS1 = 3'h6;
  localparam logic [2:0] IDX_MODE   = 3'h7;

  // Values after reset, and the counter's top value.
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST   = 8'hFF;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic       STOP_RST  = 1'b0;

  // Field positions of the timer_control byte.
  localparam int TC_MB_IE    = 7;
  localparam int TC_MA_IE    = 6;
  localparam int TC_WR_IE    = 5;
  localparam int TC_CLR_LSB  = 3;
  localparam int TC_CKS_LSB  = 0;
  // Field positions of the counter_source_control byte (upper byte).
  localparam int CSC_RLS      = 11;
  localparam int CSC_ICKS_LSB = 8;
  // Field positions of timer_flags_and_output.
  localparam int FL_MB      = 7;
  localparam int FL_MA      = 6;
  localparam int FL_WR      = 5;
  localparam int FL_ADC     = 4;
  localparam int FL_OSB_LSB = 2;
  localparam int FL_OSA_LSB = 0;
  // Field positions of the mode register.
  localparam int MODE_STOP     = 0;
  localparam int MODE_CASC_LSB = 1;

  // Clock select codes; 1 to 6 pick the prescaler taps in order.
  localparam logic [2:0] CKS_OFF = 3'h0;
  localparam logic [2:0] CKS_EXT = 3'h7;

  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A    = 2'h1;
  localparam logic [1:0] CLR_B    = 2'h2;
  localparam logic [1:0] CLR_EXT  = 2'h3;

  localparam logic [1:0] OS_KEEP   = 2'h0;
  localparam logic [1:0] OS_LOW    = 2'h1;
  localparam logic [1:0] OS_HIGH   = 2'h2;
  localparam logic [1:0] OS_TOGGLE = 2'h3;

  localparam logic [1:0] CASC_NONE  = 2'h0;
  localparam logic [1:0] CASC_16    = 2'h1;
  localparam logic [1:0] CASC_MATCH = 2'h2;

  // Tap masks for divisions by 2, 8, 32, 64, 1024 and 8192.
  localparam logic [PRESC_W-1:0] DIV_MASK [DIV_N] = '{
    13'h0001, 13'h0007, 13'h001F, 13'h003F, 13'h03FF, 13'h1FFF};
endpackage
`default_nettype wire

/* design/prescale_if.sv */
// Prescaler tap pulses and run request between timer and prescaler.
`default_nettype none
interface prescale_if;
  import dual_timer_pkg::*;
  logic             run;
  logic [DIV_N-1:0] tick;
  modport src (input run, output tick);
  modport dst (output run, input tick);
endinterface
`default_nettype wire

/* design/dual_timer_prescaler.sv */
// Divider, frozen while run is low, producing one-cycle tap pulses.
`default_nettype none
module dual_timer_prescaler
  import dual_timer_pkg::*;
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // Tap pulses
  prescale_if.src   presc
);
  typedef struct packed {
    logic [PRESC_W-1:0] cnt;
    logic [DIV_N-1:0]   tick;
  } presc_s;

  presc_s st_reg;
  presc_s st_next;

  // The divider freezes while stopped so every tap restarts in phase.
  always_comb begin
    st_next = st_reg;
    st_next.tick = '0;
    if (presc.run) begin
      st_next.cnt = st_reg.cnt + 13'h0001; // see [RQ1]
      for (int i = 0; i < DIV_N; i++) begin
        st_next.tick[i] = (st_reg.cnt & DIV_MASK[i]) == DIV_MASK[i];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign presc.tick = st_reg.tick;
endmodule
`default_nettype wire

/* design/dual_channel_8bit_timer.sv */
// Two 8-bit compare timers with cascade modes and a register port.
//
// Function
// [RQ1] Counter advances on one of six prescaler taps or the external clock.
// [RQ2] Counter clears on compare match A, compare match B or external reset.
// [RQ3] Output pin level comes from combining both compare match events.
// [RQ4] Sixteen-bit mode: channel 0 is the upper byte, channel 1 lower.
// [RQ5] Match count mode: channel 1 counts channel 0 compare A matches.
// [RQ6] Each channel requests match A, match B and wrap independently.
// [RQ7] Compare match A of channel 0 can trigger an A/D conversion.
// [RQ8] A stop state halts all counting and events.
// [RQ9] Each channel has an output pin, clock input and reset input.
// [RQ10] Counter is an 8-bit up-counter reset to zero; wrap sets flag.
// [RQ11] Counters and compare registers of both channels pair into words.
// [RQ12] Compare A resets to all ones; a match sets the match A flag.
// [RQ13] Compare B resets to all ones; a match sets the match B flag.
// [RQ14] Comparison is suppressed while that compare register is written.
// [RQ15] Match A and match B each act through own two-bit output select.
// [RQ16] Clear select: 00 none, 01 match A, 10 match B, 11 external.
// [RQ17] Reset level select: 0 clears on rising edge, 1 while high.
// [RQ18] Interrupt requests only while enable and flag are both set.
// [RQ19] A clearing match makes the next count zero instead of advancing.
//
// Local design decisions: the placing of the registers and the strobed register port.
`default_nettype none
module dual_channel_8bit_timer
  import dual_timer_pkg::*;
(
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  output logic      [DATA_W-1:0] rd_data_o,
  // Timer pins
  input  wire logic [CH_N-1:0]   ext_count_clk_pin_i,
  input  wire logic [CH_N-1:0]   ext_counter_reset_pin_i,
  output logic      [CH_N-1:0]   timer_out_pin_o,
  // Requests
  output logic      [CH_N-1:0]   match_a_irq_o,
  output logic      [CH_N-1:0]   match_b_irq_o,
  output logic      [CH_N-1:0]   wrap_irq_o,
  output logic                   adc_trigger_o
);
  typedef struct packed {
    // Channel 0 sits in the upper byte of each paired word, as in 16-bit
    // mode, so a word read of the counters gives the cascaded count.
    logic [0:CH_N-1][7:0] cnt;
    logic [0:CH_N-1][7:0] cmpa;
    logic [0:CH_N-1][7:0] cmpb;
    logic [CH_N-1:0][7:0] timer_control;
    logic [CH_N-1:0]      rls;
    logic [CH_N-1:0][1:0] icks;
    logic [CH_N-1:0]      fa;
    logic [CH_N-1:0]      fb;
    logic [CH_N-1:0]      fw;
    logic [CH_N-1:0][1:0] osa;
    logic [CH_N-1:0][1:0] osb;
    logic                 adc_en;
    logic                 stop;
    logic [1:0]           casc;
    logic [CH_N-1:0]      eqa_prev;
    logic [CH_N-1:0]      eqb_prev;
    logic [CH_N-1:0]      clk_prev;
    logic [CH_N-1:0]      rst_prev;
    logic [CH_N-1:0]      pin;
    logic [CH_N-1:0]      irq_a;
    logic [CH_N-1:0]      irq_b;
    logic [CH_N-1:0]      irq_w;
    logic                 adc;
    logic [DATA_W-1:0]    rdata;
  } timer_s;

  timer_s          st_reg;
  timer_s          st_next;
  logic [CH_N-1:0] eq_a;
  logic [CH_N-1:0] eq_b;
  logic [CH_N-1:0] ma_evt;
  logic [CH_N-1:0] mb_evt;
  logic [CH_N-1:0] tick;
  logic [CH_N-1:0] cmp_clr;
  logic [CH_N-1:0] ext_clr;
  logic [CH_N-1:0] wrap;
  logic            wr_cnt;
  logic            wr_cmpa;
  logic            wr_cmpb;

  prescale_if presc ();

  dual_timer_prescaler u_presc (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .presc     (presc)
  );

  assign presc.run = !st_reg.stop; // see [RQ8]

  // Picks the count pulse for a clock select code.
  function automatic logic src_tick(input logic [2:0]       sel,
                                    input logic [DIV_N-1:0] taps,
                                    input logic             ext_edge);
    logic hit;
    hit = 1'b0;
    if (sel == CKS_EXT) begin
      hit = ext_edge;
    end else if (sel != CKS_OFF) begin
      hit = taps[sel - 3'h1];
    end
    return hit;
  endfunction

  // Applies one output select code to the present pin level.
  function automatic logic out_apply(input logic       lvl,
                                     input logic [1:0] sel);
    logic res;
    res = lvl;
    case (sel)
      OS_LOW:    res = 1'b0;
      OS_HIGH:   res = 1'b1;
      OS_TOGGLE: res = !lvl;
      default:   res = lvl;
    endcase
    return res;
  endfunction

  always_comb begin
    st_next = st_reg;
    wr_cnt  = wr_en_i && (addr_i == IDX_COUNT);
    wr_cmpa = wr_en_i && (addr_i == IDX_CMPA);
    wr_cmpb = wr_en_i && (addr_i == IDX_CMPB);
    tick    = '0;
    cmp_clr = '0;
    ext_clr = '0;
    wrap    = '0;
    // A write hides the match in its own cycle so a half-updated
    // compare value never produces a spurious event.
    for (int i = 0; i < CH_N; i++) begin
      eq_a[i] = (st_reg.cnt[i] == st_reg.cmpa[i]) && !wr_cmpa; // see [RQ14]
      eq_b[i] = (st_reg.cnt[i] == st_reg.cmpb[i]) && !wr_cmpb; // see [RQ14]
      ma_evt[i] = eq_a[i] && !st_reg.eqa_prev[i] && !st_reg.stop; // see [RQ12]
      mb_evt[i] = eq_b[i] && !st_reg.eqb_prev[i] && !st_reg.stop; // see [RQ13]
    end
    // Channel 1 first: channel 0 may count its wraps in 16-bit mode.
    for (int i = CH_N - 1; i >= 0; i--) begin
      tick[i] = !st_reg.stop && src_tick(st_reg.timer_control[i][TC_CKS_LSB +: 3],
        presc.tick, ext_count_clk_pin_i[i] && !st_reg.clk_prev[i]); // see [RQ1]
      if (i == 1 && st_reg.casc == CASC_MATCH) begin
        tick[i] = ma_evt[0]; // see [RQ5]
      end
      if (i == 0 && st_reg.casc == CASC_16) begin
        tick[i] = wrap[1]; // see [RQ4]
      end
      case (st_reg.timer_control[i][TC_CLR_LSB +: 2]) // see [RQ16]
        CLR_A:   cmp_clr[i] = tick[i] && eq_a[i]; // see [RQ19]
        CLR_B:   cmp_clr[i] = tick[i] && eq_b[i]; // see [RQ19]
        CLR_EXT: ext_clr[i] = !st_reg.stop && (st_reg.rls[i] ?
                   ext_counter_reset_pin_i[i] :
                   ext_counter_reset_pin_i[i] && !st_reg.rst_prev[i]); // see [RQ17]
        default: cmp_clr[i] = 1'b0;
      endcase
      wrap[i] = tick[i] && (st_reg.cnt[i] == COUNT_MAX) &&
                !cmp_clr[i] && !ext_clr[i]; // see [RQ10]
      if (cmp_clr[i] || ext_clr[i]) begin
        st_next.cnt[i] = COUNT_RST; // see [RQ2]
      end else if (tick[i]) begin
        st_next.cnt[i] = st_reg.cnt[i] + 8'h01; // see [RQ10]
      end
      // Match B acts first so match A decides when both coincide.
      if (mb_evt[i]) begin
        st_next.pin[i] = out_apply(st_next.pin[i], st_reg.osb[i]); // see [RQ15]
      end
      if (ma_evt[i]) begin
        st_next.pin[i] = out_apply(st_next.pin[i], st_reg.osa[i]); // see [RQ3]
      end
    end
    // Software writes to a counter win over counting in the same cycle.
    if (wr_cnt) begin
      st_next.cnt = wr_data_i; // see [RQ11]
    end
    if (wr_cmpa) begin
      st_next.cmpa = wr_data_i; // see [RQ11]
    end
    if (wr_cmpb) begin
      st_next.cmpb = wr_data_i;
    end
    for (int i = 0; i < CH_N; i++) begin
      if (wr_en_i && addr_i == (i == 0 ? IDX_CTRL0 : IDX_CTRL1)) begin
        st_next.timer_control[i]  = wr_data_i[7:0];
        st_next.rls[i]  = wr_data_i[CSC_RLS];
        st_next.icks[i] = wr_data_i[CSC_ICKS_LSB +: 2];
      end
      // Flags clear by writing zero; an event in the same cycle wins.
      if (wr_en_i && addr_i == (i == 0 ? IDX_FLAGS0 : IDX_FLAGS1)) begin
        st_next.fa[i]  = st_reg.fa[i] && wr_data_i[FL_MA];
        st_next.fb[i]  = st_reg.fb[i] && wr_data_i[FL_MB];
        st_next.fw[i]  = st_reg.fw[i] && wr_data_i[FL_WR];
        st_next.osa[i] = wr_data_i[FL_OSA_LSB +: 2];
        st_next.osb[i] = wr_data_i[FL_OSB_LSB +: 2];
        if (i == 0) begin
          st_next.adc_en = wr_data_i[FL_ADC];
        end
      end
      st_next.fa[i] = st_next.fa[i] || ma_evt[i]; // see [RQ12]
      st_next.fb[i] = st_next.fb[i] || mb_evt[i]; // see [RQ13]
      st_next.fw[i] = st_next.fw[i] || wrap[i]; // see [RQ10]
    end
    if (wr_en_i && addr_i == IDX_MODE) begin
      st_next.stop = wr_data_i[MODE_STOP];
      st_next.casc = wr_data_i[MODE_CASC_LSB +: 2];
    end
    for (int i = 0; i < CH_N; i++) begin
      st_next.irq_a[i] = st_next.timer_control[i][TC_MA_IE] && st_next.fa[i]; // see [RQ18]
      st_next.irq_b[i] = st_next.timer_control[i][TC_MB_IE] && st_next.fb[i]; // see [RQ6]
      st_next.irq_w[i] = st_next.timer_control[i][TC_WR_IE] && st_next.fw[i]; // see [RQ6]
    end
    st_next.adc      = ma_evt[0] && st_reg.adc_en; // see [RQ7]
    st_next.eqa_prev = eq_a;
    st_next.eqb_prev = eq_b;
    st_next.clk_prev = ext_count_clk_pin_i; // see [RQ9]
    st_next.rst_prev = ext_counter_reset_pin_i;
    st_next.rdata    = '0;
    if (rd_en_i) begin
      case (addr_i)
        IDX_COUNT:  st_next.rdata = st_reg.cnt;
        IDX_CMPA:   st_next.rdata = st_reg.cmpa;
        IDX_CMPB:   st_next.rdata = st_reg.cmpb;
        IDX_CTRL0:  st_next.rdata = {4'h0, st_reg.rls[0], 1'b0,
                                     st_reg.icks[0], st_reg.timer_control[0]};
        IDX_CTRL1:  st_next.rdata = {4'h0, st_reg.rls[1], 1'b0,
                                     st_reg.icks[1], st_reg.timer_control[1]};
        IDX_FLAGS0: st_next.rdata = {8'h00, st_reg.fb[0], st_reg.fa[0],
                                     st_reg.fw[0], st_reg.adc_en,
                                     st_reg.osb[0], st_reg.osa[0]};
        IDX_FLAGS1: st_next.rdata = {8'h00, st_reg.fb[1], st_reg.fa[1],
                                     st_reg.fw[1], 1'b0,
                                     st_reg.osb[1], st_reg.osa[1]};
        IDX_MODE:   st_next.rdata = {13'h0000, st_reg.casc, st_reg.stop};
        default:    st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_reg      <= '0;
      st_reg.cnt  <= {COUNT_RST, COUNT_RST};
      st_reg.cmpa <= {CMP_RST, CMP_RST};
      st_reg.cmpb <= {CMP_RST, CMP_RST};
      st_reg.timer_control  <= {CTRL_RST, CTRL_RST};
      st_reg.stop <= STOP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data_o       = st_reg.rdata;
  assign timer_out_pin_o = st_reg.pin;
  assign match_a_irq_o   = st_reg.irq_a;
  assign match_b_irq_o   = st_reg.irq_b;
  assign wrap_irq_o      = st_reg.irq_w;
  assign adc_trigger_o   = st_reg.adc;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  chk_reset_values: assert property ( // see [RQ12]
    $past(sys_rst_i) |-> st_reg.cnt == 16'h0000 && st_reg.cmpa == 16'hFFFF
      && st_reg.cmpb == 16'hFFFF)
    else $error("Registers wrong after reset.");
  chk_wrap_sets_flag: assert property ( // see [RQ10]
    wrap[1] && !(wr_en_i && addr_i == IDX_FLAGS1) && !wr_cnt
      |=> st_reg.fw[1] && st_reg.cnt[1] == 8'h00)
    else $error("Wrap did not zero counter and set flag.");
  chk_match_sets_flag: assert property ( // see [RQ13]
    mb_evt[0] |=> st_reg.fb[0])
    else $error("Match B flag not set.");
  chk_write_hides_cmp: assert property ( // see [RQ14]
    wr_cmpa |-> eq_a == 2'b00 && ma_evt == 2'b00
      ##1 st_reg.fa == $past(st_reg.fa))
    else $error("Compare A matched during its write.");
  chk_clear_on_match: assert property ( // see [RQ19]
    st_reg.timer_control[1][TC_CLR_LSB +: 2] == CLR_A && tick[1] && eq_a[1] && !wr_cnt
      |=> st_reg.cnt[1] == 8'h00)
    else $error("Counter not cleared after match A.");
  chk_level_reset: assert property ( // see [RQ17]
    st_reg.timer_control[0][TC_CLR_LSB +: 2] == CLR_EXT && st_reg.rls[0] && !st_reg.stop
      && ext_counter_reset_pin_i[0] && !wr_cnt [*2]
      |=> st_reg.cnt[0] == 8'h00)
    else $error("Counter not held at zero by reset level.");
  chk_irq_gating: assert property ( // see [RQ18]
    match_a_irq_o[0] == (st_reg.timer_control[0][TC_MA_IE] && st_reg.fa[0])
      && wrap_irq_o[1] == (st_reg.timer_control[1][TC_WR_IE] && st_reg.fw[1]))
    else $error("Interrupt request not equal to enable and flag.");
  chk_cascade_carry: assert property ( // see [RQ4]
    st_reg.casc == CASC_16 && wrap[1] && !wr_cnt
      && st_reg.timer_control[0][TC_CLR_LSB +: 2] == CLR_NONE
      |=> st_reg.cnt[0] == $past(st_reg.cnt[0]) + 8'h01)
    else $error("Upper byte did not carry.");
  chk_match_count: assert property ( // see [RQ5]
    st_reg.casc == CASC_MATCH && !st_reg.stop |-> tick[1] == ma_evt[0])
    else $error("Channel 1 not counting channel 0 matches.");
  chk_stop_holds: assert property ( // see [RQ8]
    st_reg.stop && !wr_cnt |=> $stable(st_reg.cnt) && !adc_trigger_o)
    else $error("Counter moved while stopped.");
  chk_adc_pulse: assert property ( // see [RQ7]
    ma_evt[0] && st_reg.adc_en |=> adc_trigger_o ##1 !adc_trigger_o)
    else $error("A/D trigger pulse missing.");
  chk_read_one_cycle: assert property ( // see [RQ11]
    !$past(rd_en_i) |-> rd_data_o == 16'h0000)
    else $error("Read data outside its cycle.");
endmodule
`default_nettype wire

/* sim/timer_pins_model.sv */
// Far-side model: external count clock and counter reset sources.
`default_nettype none
module timer_pins_model (
  // Clock
  input  wire logic       clock_i,
  // Commands from the bench
  input  wire logic [1:0] clk_run_i,
  input  wire logic [1:0] rst_hold_i,
  // Pins toward the timer
  output var logic  [1:0] count_clk_o = 2'h0,
  output var logic  [1:0] counter_reset_o = 2'h0
);
  timeunit 1ns;
  timeprecision 1ps;

  // The count clock stands low between bursts, so no stray edge is counted.
  always @(posedge clock_i) begin
    for (int c = 0; c < 2; c++) begin
      count_clk_o[c] <= clk_run_i[c] ? ~count_clk_o[c] : 1'b0;
    end
    counter_reset_o <= rst_hold_i;
  end
endmodule
`default_nettype wire

/* sim/dual_channel_8bit_timer_tb.sv */
// Self-checking bench for the dual 8-bit timer.
`default_nettype none
module dual_channel_8bit_timer_tb
  import dual_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clock_i   = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i    = '0;
  logic [DATA_W-1:0] wr_data_i = '0;
  logic              wr_en_i   = 1'b0;
  logic              rd_en_i   = 1'b0;
  logic [DATA_W-1:0] rd_data_o;
  logic [CH_N-1:0]   ext_clk;
  logic [CH_N-1:0]   ext_rst;
  logic [CH_N-1:0]   pin_o;
  logic [CH_N-1:0]   ma_irq;
  logic [CH_N-1:0]   mb_irq;
  logic [CH_N-1:0]   wr_irq;
  logic              adc;
  logic [1:0]        clk_run   = 2'h0;
  logic [1:0]        rst_hold  = 2'h0;
  int                errors    = 0;
  int                compares  = 0;
  int                cycles    = 0;

  always #5 clock_i = ~clock_i;

  dual_channel_8bit_timer DUT (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o), .ext_count_clk_pin_i(ext_clk),
    .ext_counter_reset_pin_i(ext_rst), .timer_out_pin_o(pin_o),
    .match_a_irq_o(ma_irq), .match_b_irq_o(mb_irq),
    .wrap_irq_o(wr_irq), .adc_trigger_o(adc));

  timer_pins_model pins (
    .clock_i(clock_i), .clk_run_i(clk_run), .rst_hold_i(rst_hold),
    .count_clk_o(ext_clk), .counter_reset_o(ext_rst));

  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A hang counts as a mismatch; the tests need well under a thousand cycles.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      close_out();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Every task returns 1 ns after an edge, so outputs are settled there.
  task automatic run(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge clock_i);
    wr_en_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clock_i);
    rd_en_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask

  task automatic pulse(input int n);
    clk_run[0] <= 1'b1;
    run(n);
    clk_run[0] <= 1'b0;
    run(4);
  endtask

  task automatic t_reset();
    logic [15:0] d;
    logic [15:0] exp [8] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000,
                             16'h0000, 16'h0000, 16'h0000, 16'h0000};
    check({ma_irq, mb_irq, wr_irq, pin_o, 7'h00, adc}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      check(d, exp[i]);
    end
    wr(IDX_CMPA, 16'h1234);
    wr(IDX_CMPB, 16'hA55A);
    rd(IDX_CMPA, d);
    check(d, 16'h1234);
    rd(IDX_CMPB, d);
    check(d, 16'hA55A);
    $display("test reset_values done");
  endtask

  task automatic t_clear();
    logic [15:0] d;
    logic [15:0] hi;
    for (int s = 1; s <= 2; s++) begin
      hi = 16'h0000;
      wr(IDX_MODE, 16'h0001);
      wr(IDX_COUNT, 16'h0000);
      wr(IDX_CMPA, s == 1 ? 16'h02FF : 16'hFFFF);
      wr(IDX_CMPB, s == 1 ? 16'hFFFF : 16'h02FF);
      wr(IDX_FLAGS0, 16'h0000);
      wr(IDX_CTRL0, (16'(s) << 3) | 16'h00C1);
      wr(IDX_MODE, 16'h0000);
      for (int i = 0; i < 16; i++) begin
        rd(IDX_COUNT, d);
        if (d > hi) hi = d;
      end
      check(hi, 16'h0200);
      wr(IDX_MODE, 16'h0001);
      rd(IDX_FLAGS0, d);
      check(d & 16'h00C0, s == 1 ? 16'h0040 : 16'h0080);
      check({14'h0, ma_irq[0], mb_irq[0]}, 16'(3 - s));
      rd(IDX_COUNT, hi);
      run(6);
      rd(IDX_COUNT, d);
      check(d, hi);
      wr(IDX_FLAGS0, 16'h0000);
      run(1);
      check({14'h0, ma_irq[0], mb_irq[0]}, 16'h0000);
    end
    $display("test compare_clear done");
  endtask

  task automatic t_wrap();
    logic [15:0] d;
    for (int m = 0; m < 2; m++) begin
      wr(IDX_MODE, 16'h0001);
      wr(IDX_CTRL0, 16'h0000);
      wr(IDX_COUNT, 16'h00FD);
      wr(IDX_FLAGS1, 16'h0000);
      wr(IDX_CTRL1, 16'h0021);
      wr(IDX_MODE, m == 1 ? 16'h0002 : 16'h0000);
      run(12);
      wr(IDX_MODE, 16'h0001);
      rd(IDX_COUNT, d);
      check({8'h00, d[15:8]}, 16'(m));
      check({15'h0, d[7:0] < 8'h10}, 16'h0001);
      rd(IDX_FLAGS1, d);
      check(d & 16'h0020, 16'h0020);
      check({15'h0, wr_irq[1]}, 16'h0001);
    end
    $display("test wrap_and_cascade done");
  endtask

  task automatic t_ext();
    logic [15:0] d;
    wr(IDX_MODE, 16'h0000);
    wr(IDX_COUNT, 16'h0000);
    wr(IDX_CTRL0, 16'h0007);
    pulse(20);
    rd(IDX_COUNT, d);
    check({8'h00, d[15:8]}, 16'h000A);
    wr(IDX_CTRL0, 16'h081F);
    rst_hold[0] <= 1'b1;
    pulse(10);
    rd(IDX_COUNT, d);
    check({8'h00, d[15:8]}, 16'h0000);
    wr(IDX_CTRL0, 16'h001F);
    pulse(8);
    rd(IDX_COUNT, d);
    check({8'h00, d[15:8]}, 16'h0004);
    rst_hold[0] <= 1'b0;
    run(3);
    rst_hold[0] <= 1'b1;
    run(4);
    rd(IDX_COUNT, d);
    check({8'h00, d[15:8]}, 16'h0000);
    rst_hold[0] <= 1'b0;
    $display("test external_pins done");
  endtask

  task automatic t_pin();
    int up;
    int dn;
    int adc_n;
    wr(IDX_MODE, 16'h0001);
    wr(IDX_COUNT, 16'h0000);
    wr(IDX_CMPA, 16'h04FF);
    wr(IDX_CMPB, 16'h08FF);
    wr(IDX_FLAGS0, 16'h0016);
    wr(IDX_CTRL0, 16'h0001);
    wr(IDX_MODE, 16'h0000);
    up = -1;
    dn = -1;
    adc_n = 0;
    for (int i = 0; i < 100 && dn < 0; i++) begin
      run(1);
      if (adc === 1'b1) adc_n++;
      if (up < 0 && pin_o[0] === 1'b1) up = i;
      if (up >= 0 && pin_o[0] === 1'b0) dn = i;
    end
    // Matches at 4 and 8 on the divide-by-2 tap lie eight cycles apart.
    check(16'(dn - up), 16'h0008);
    check(16'(adc_n), 16'h0001);
    $display("test output_pin done");
  endtask

  task automatic t_mcount();
    logic [15:0] d;
    wr(IDX_MODE, 16'h0001);
    wr(IDX_COUNT, 16'h0000);
    wr(IDX_CMPA, 16'h01FF);
    wr(IDX_CTRL1, 16'h0000);
    wr(IDX_CTRL0, 16'h0009);
    wr(IDX_MODE, 16'h0004);
    run(40);
    wr(IDX_MODE, 16'h0001);
    rd(IDX_COUNT, d);
    check({15'h0, d[7:0] >= 8'h08 && d[7:0] <= 8'h0C}, 16'h0001);
    $display("test match_count done");
  endtask

  // The prescaler runs for exactly 128 cycles, a multiple of the 8, 32 and 64 taps tested.
  task automatic t_taps();
    logic [15:0] d;
    int          n;
    for (int k = 2; k <= 4; k++) begin
      n = int'(DIV_MASK[k - 1]) + 1;
      wr(IDX_MODE, 16'h0001);
      wr(IDX_COUNT, 16'h0000);
      wr(IDX_CTRL0, 16'(k));
      wr(IDX_MODE, 16'h0000);
      run(128);
      wr(IDX_MODE, 16'h0001);
      rd(IDX_COUNT, d);
      check({8'h00, d[15:8]}, 16'(128 / n));
    end
    $display("test prescaler_taps done");
  endtask

  initial begin
    run(3);
    sys_rst_i <= 1'b0;
    run(1);
    t_reset();
    t_clear();
    t_wrap();
    t_ext();
    t_pin();
    t_mcount();
    t_taps();
    close_out();
  end
endmodule
`default_nettype wire
